/* core/dsrw_regs.svh */
// Purpose: Constants for the drive status and reference word block.
// Assumes: One 10 MHz clock; words are 16 bits wide.
// Notes: Field positions, scaling, reset values and divider step counts only.
`ifndef DSRW_REGS_SVH
`define DSRW_REGS_SVH

// Status word bit positions
`define DSRW_SW_BUS_CTRL 4'h9
`define DSRW_SW_FREQ_OK 4'hA
`define DSRW_SW_RUNNING 4'hB
`define DSRW_SW_AUTO_RST 4'hC
`define DSRW_SW_VOLT_EXC 4'hD
`define DSRW_SW_CURR_EXC 4'hE
`define DSRW_SW_THERM_EXC 4'hF

// Command word bit positions
`define DSRW_CW_COAST_N 4'h3
`define DSRW_CW_RAMP_RUN 4'h6
`define DSRW_CW_VALID 4'hA

// Scaling: 16384 is full scale
`define DSRW_FULL_SCALE 16'h4000
`define DSRW_FULL_SCALE_SH 5'h0E
`define DSRW_POS_SAT 16'h7FFF

// Reset values
`define DSRW_SW_RST 16'h0000
`define DSRW_CMD_RST 16'h0000
`define DSRW_SP_RST 16'h0000
`define DSRW_REP_RST 16'h0000

// Divider: numerator is 16 magnitude bits shifted left by 14
`define DSRW_DIV_BITS 5'h1E
`define DSRW_DIV_LAST 5'h1D

`endif

/* core/dsrw_pkg.sv */
// Purpose: Types shared by the drive status and reference word block.
// Assumes: Constants live in dsrw_regs.svh.
// Notes: Thermal halt states are Gray coded along ok, halt, trip.
package dsrw_pkg;

  typedef enum logic [1:0] {
    DSRW_ST_OK = 2'b00,
    DSRW_ST_HALT = 2'b01,
    DSRW_ST_TRIP = 2'b11
  } dsrw_therm_e;

  typedef struct packed {
    dsrw_therm_e st;
    logic [15:0] sw;
    logic [15:0] cmd;
    logic [15:0] sp;
    logic [15:0] rep;
    logic taken;
    logic busy;
    logic neg;
    logic [4:0] cnt;
    logic [29:0] num;
    logic [16:0] rem;
    logic [29:0] quo;
    logic [15:0] den;
  } dsrw_state_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
  } dsrw_sync_s;

endpackage

/* core/dsrw_sync.sv */
// Purpose: Two-stage synchroniser for the asynchronous pin inputs.
// Assumes: Pins are slow levels; no edge is narrower than two clocks.
// Notes: Only the second stage is visible to the rest of the block.
module dsrw_sync
  import dsrw_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic [4:0] pin_i, // Raw pin levels
  output logic [4:0] pin_o // Synchronised levels
);

  dsrw_sync_s q_r;
  dsrw_sync_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pin_i;
    q_nxt.s2 = q_r.s1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pin_o = q_r.s2;

endmodule

/* core/dsrw_top.sv */
// Purpose: Status word assembly, command and speed reference intake,
//   and scaled reporting of the actual output frequency.
// Assumes: Frequencies, limits and maximum share one unsigned unit;
//   current, limits and thermal timers come from same-clock logic.
// Notes: Status bits 0 to 8 read zero; they belong to another block.
`include "dsrw_regs.svh"

module dsrw_top
  import dsrw_pkg::*;
(
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire logic off_key_i, // Panel off/reset key pin
  input wire logic start_local_i, // Local start pin
  input wire logic coast_local_i, // Local coast request pin
  input wire logic dc_low_i, // DC link undervoltage comparator pin
  input wire logic dc_high_i, // DC link overvoltage comparator pin
  input wire logic local_site_i, // Local reference site selected
  input wire logic overtemp_i, // Temporary overtemperature flag
  input wire logic trip_i, // Drive tripped
  input wire logic [15:0] motor_current_i, // Measured motor current
  input wire logic [15:0] current_limit_i, // Configured current limit
  input wire logic [15:0] motor_timer_i, // Motor thermal timer
  input wire logic [15:0] drive_timer_i, // Drive thermal timer
  input wire logic [15:0] out_freq_i, // Signed actual output frequency
  input wire logic freq_upd_i, // Pulse: out_freq_i is new
  input wire logic [15:0] freq_low_lim_i, // Low speed limit
  input wire logic [15:0] freq_high_lim_i, // High speed limit
  input wire logic [15:0] freq_max_i, // Frequency at full scale
  input wire logic cmd_stb_i, // Pulse: command and reference present
  input wire logic [15:0] command_word_i, // Command word from master
  input wire logic [15:0] speed_setpoint_word_i, // Reference word
  output logic [15:0] drive_state_word_o, // Registered status word
  output logic [15:0] reported_frequency_word_o, // Scaled frequency
  output logic [15:0] command_word_o, // Last accepted command word
  output logic [15:0] speed_setpoint_o, // Last accepted reference
  output logic [15:0] target_freq_o, // Reference in frequency units
  output logic cmd_taken_o, // Pulse: command word accepted
  output logic run_o, // Start active without coast
  output logic conv_busy_o // Frequency scaling in progress
);

  dsrw_state_s q_r;
  dsrw_state_s q_nxt;
  logic [4:0] pin_s;
  logic off_key_s;
  logic start_local_s;
  logic coast_local_s;
  logic dc_low_s;
  logic dc_high_s;
  logic bus_ctrl;
  logic start_act;
  logic coast_act;
  logic freq_in_lim;
  logic [15:0] freq_mag;
  logic [16:0] rem_sh;
  logic [16:0] rem_sub;
  logic [15:0] mag_q;
  logic [31:0] target_prod;

  // Magnitude of a signed 16-bit word; -32768 maps to 32768
  function automatic logic [15:0] mag16(input logic [15:0] v);
    logic [15:0] r;
    r = v[15] ? (~v + 16'h0001) : v;
    return r;
  endfunction

  // Timer above full scale, used for both thermal timers
  function automatic logic over_full(input logic [15:0] t);
    logic r;
    r = (t > `DSRW_FULL_SCALE);
    return r;
  endfunction

  dsrw_sync u_sync (
    .clk_i (clk_i),
    .nrst_i (nrst_i),
    .pin_i ({dc_high_i, dc_low_i, coast_local_i, start_local_i,
      off_key_i}),
    .pin_o (pin_s)
  );

  assign off_key_s = pin_s[0];
  assign start_local_s = pin_s[1];
  assign coast_local_s = pin_s[2];
  assign dc_low_s = pin_s[3];
  assign dc_high_s = pin_s[4];

  assign bus_ctrl = !off_key_s && !local_site_i;

  // Source of start and coast follows the controlling site
  assign start_act = bus_ctrl ? q_r.cmd[`DSRW_CW_RAMP_RUN] : start_local_s;
  assign coast_act = bus_ctrl ? !q_r.cmd[`DSRW_CW_COAST_N] : coast_local_s;

  assign freq_mag = mag16(out_freq_i);

  assign freq_in_lim = (freq_mag > freq_low_lim_i) &&
    (freq_mag < freq_high_lim_i);

  // Long division step on the magnitude times full scale
  assign rem_sh = {q_r.rem[15:0], q_r.num[29]};
  assign rem_sub = rem_sh - {1'b0, q_r.den};

  // Quotients that do not fit 15 bits saturate to the positive maximum
  assign mag_q = (|q_r.quo[29:15]) ? `DSRW_POS_SAT : {1'b0, q_r.quo[14:0]};

  // Reference times maximum over full scale
  assign target_prod = $signed(q_r.sp) * $signed({1'b0, freq_max_i[14:0]});

  always_comb begin
    q_nxt = q_r;
    q_nxt.taken = 1'b0;

    if (cmd_stb_i && bus_ctrl && command_word_i[`DSRW_CW_VALID]) begin
      q_nxt.cmd = command_word_i;
      q_nxt.sp = speed_setpoint_word_i;
      q_nxt.taken = 1'b1;
    end

    case (q_r.st)
      DSRW_ST_OK: begin
        if (trip_i) begin
          q_nxt.st = DSRW_ST_TRIP;
        end else if (overtemp_i) begin
          q_nxt.st = DSRW_ST_HALT;
        end
      end
      DSRW_ST_HALT: begin
        if (trip_i) begin
          q_nxt.st = DSRW_ST_TRIP;
        end else if (!overtemp_i) begin
          q_nxt.st = DSRW_ST_OK;
        end
      end
      DSRW_ST_TRIP: begin
        // A trip returns to ok by itself once trip and overtemperature both clear
        if (!trip_i && !overtemp_i) begin
          q_nxt.st = DSRW_ST_OK;
        end
      end
      default: begin
        q_nxt.st = DSRW_ST_OK;
      end
    endcase

    q_nxt.sw = `DSRW_SW_RST;
    q_nxt.sw[`DSRW_SW_BUS_CTRL] = bus_ctrl;
    q_nxt.sw[`DSRW_SW_FREQ_OK] = freq_in_lim;
    q_nxt.sw[`DSRW_SW_RUNNING] = start_act && !coast_act;
    q_nxt.sw[`DSRW_SW_AUTO_RST] = (q_r.st == DSRW_ST_HALT);
    q_nxt.sw[`DSRW_SW_VOLT_EXC] = dc_low_s || dc_high_s;
    q_nxt.sw[`DSRW_SW_CURR_EXC] = (motor_current_i > current_limit_i);
    q_nxt.sw[`DSRW_SW_THERM_EXC] = over_full(motor_timer_i) ||
      over_full(drive_timer_i);

    if (!q_r.busy) begin
      // Updates arriving during a conversion are dropped; the next
      // one is taken, so the report can trail by every update dropped meanwhile
      if (freq_upd_i) begin
        if (freq_max_i == 16'h0000) begin
          q_nxt.rep = `DSRW_REP_RST;
        end else begin
          q_nxt.busy = 1'b1;
          q_nxt.cnt = 5'h00;
          q_nxt.neg = out_freq_i[15];
          q_nxt.num = {freq_mag, 14'h0000};
          q_nxt.rem = 17'h00000;
          q_nxt.quo = 30'h00000000;
          q_nxt.den = freq_max_i;
        end
      end
    end else begin
      q_nxt.num = {q_r.num[28:0], 1'b0};
      if (!rem_sub[16]) begin
        q_nxt.rem = rem_sub;
        q_nxt.quo = {q_r.quo[28:0], 1'b1};
      end else begin
        q_nxt.rem = rem_sh;
        q_nxt.quo = {q_r.quo[28:0], 1'b0};
      end
      q_nxt.cnt = q_r.cnt + 5'h01;
      if (q_r.cnt == `DSRW_DIV_LAST) begin
        q_nxt.busy = 1'b0;
      end
    end

    // Final quotient is stored the cycle after the last step; the old
    // word stands until then, so a read never sees a cleared report
    if (!q_r.busy && q_r.cnt == `DSRW_DIV_BITS) begin
      q_nxt.rep = q_r.neg ? (~mag_q + 16'h0001) : mag_q;
      q_nxt.cnt = 5'h00;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r.st <= DSRW_ST_OK;
      q_r.sw <= `DSRW_SW_RST;
      q_r.cmd <= `DSRW_CMD_RST;
      q_r.sp <= `DSRW_SP_RST;
      q_r.rep <= `DSRW_REP_RST;
      q_r.taken <= 1'b0;
      q_r.busy <= 1'b0;
      q_r.neg <= 1'b0;
      q_r.cnt <= 5'h00;
      q_r.num <= 30'h00000000;
      q_r.rem <= 17'h00000;
      q_r.quo <= 30'h00000000;
      q_r.den <= 16'h0000;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign drive_state_word_o = q_r.sw;
  assign reported_frequency_word_o = q_r.rep;
  assign command_word_o = q_r.cmd;
  assign speed_setpoint_o = q_r.sp;
  assign target_freq_o = target_prod[29:14];
  assign cmd_taken_o = q_r.taken;
  assign run_o = q_r.sw[`DSRW_SW_RUNNING];
  assign conv_busy_o = q_r.busy || (q_r.cnt == `DSRW_DIV_BITS);

endmodule

/* testbench/dsrw_chk.sv */
// Purpose: Port checks for dsrw_top.
// Assumes: Pins reach the status word three edges after they change.
// Notes: Sees only top ports; bound below.
module dsrw_chk (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic off_key_i, // Off key pin
  input wire logic local_site_i, // Local site
  input wire logic dc_low_i, // Undervoltage pin
  input wire logic dc_high_i, // Overvoltage pin
  input wire logic [15:0] motor_current_i, // Current
  input wire logic [15:0] current_limit_i, // Current limit
  input wire logic [15:0] motor_timer_i, // Motor timer
  input wire logic [15:0] drive_timer_i, // Drive timer
  input wire logic freq_upd_i, // Frequency update
  input wire logic [15:0] freq_max_i, // Full scale frequency
  input wire logic cmd_stb_i, // Command strobe
  input wire logic [15:0] command_word_i, // Command word
  input wire logic [15:0] command_word_o, // Accepted command word
  input wire logic [15:0] drive_state_word_o, // Status word
  input wire logic cmd_taken_o, // Command accepted
  input wire logic run_o, // Running
  input wire logic conv_busy_o // Scaling busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_LOCAL: assert property (
    local_site_i |=> !drive_state_word_o[9])
    else $error("bus control bit set under local site");
  AST_OFFKEY: assert property (
    off_key_i[*3] |=> !drive_state_word_o[9])
    else $error("bus control bit set under off key");
  AST_TAKE: assert property (
    (!off_key_i && !local_site_i)[*3] ##0
    (cmd_stb_i && command_word_i[10]) |=> cmd_taken_o)
    else $error("valid command not taken");
  AST_REFUSE: assert property (
    cmd_stb_i && !command_word_i[10] |=> !cmd_taken_o)
    else $error("invalid command taken");
  AST_VOLT: assert property (
    (dc_low_i || dc_high_i)[*3] |=> drive_state_word_o[13])
    else $error("voltage bit missing");
  AST_CURR: assert property (
    nrst_i |=> drive_state_word_o[14] ==
    ($past(motor_current_i) > $past(current_limit_i)))
    else $error("current bit wrong");
  AST_THERM: assert property (
    nrst_i |=> drive_state_word_o[15] == ($past(motor_timer_i) >
    16'h4000 || $past(drive_timer_i) > 16'h4000))
    else $error("thermal bit wrong");
  AST_CONV: assert property (
    freq_upd_i && !conv_busy_o && freq_max_i != 16'h0000 |=>
    conv_busy_o[*8] ##23 conv_busy_o ##1 !conv_busy_o)
    else $error("scaling time wrong");
  AST_RUN: assert property (
    (!off_key_i && !local_site_i)[*3] |=> run_o ==
    ($past(command_word_o[6]) && $past(command_word_o[3])))
    else $error("run does not follow the bus command word");
endmodule
bind dsrw_top dsrw_chk u_chk (.*);

/* testbench/dsrw_master.sv */
// Purpose: Fieldbus master model sending command and reference pairs.
// Assumes: Caller picks the words.
// Notes: Lines show inverted stale data between strobes.
module dsrw_master (
  input wire logic clk_i, // System clock
  output logic cmd_stb_o, // Command strobe
  output logic [15:0] cmd_o, // Command word
  output logic [15:0] sp_o // Signed setpoint
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_stb_o = 1'b0;
    cmd_o = 16'h0000;
    sp_o = 16'h0000;
  end
  task automatic send(input logic [15:0] cw, input logic [15:0] sp);
    @(negedge clk_i);
    cmd_stb_o = 1'b1;
    cmd_o = cw;
    sp_o = sp;
    @(negedge clk_i);
    cmd_stb_o = 1'b0;
    cmd_o = ~cw;
    sp_o = ~sp;
  endtask
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for dsrw_top.
// Assumes: Inputs change at falling edges.
// Notes: Scaling runs are spaced past the busy window.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic off_key_i, start_local_i, coast_local_i, dc_low_i, dc_high_i;
  logic local_site_i, overtemp_i, trip_i, freq_upd_i, cmd_stb_i;
  logic [15:0] motor_current_i, current_limit_i, motor_timer_i;
  logic [15:0] drive_timer_i, out_freq_i, freq_low_lim_i;
  logic [15:0] freq_high_lim_i, freq_max_i, command_word_i;
  logic [15:0] speed_setpoint_word_i, drive_state_word_o;
  logic [15:0] reported_frequency_word_o, command_word_o;
  logic [15:0] speed_setpoint_o, target_freq_o;
  logic cmd_taken_o, run_o, conv_busy_o;
  logic [15:0] fv [4] = '{16'h0800, 16'hF800, 16'h1000, 16'h4000};
  logic [15:0] fe [4] = '{16'h2000, 16'hE000, 16'h4000, 16'h7FFF};
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  dsrw_top DUT (.*);
  dsrw_master u_mst (.clk_i(clk_i), .cmd_stb_o(cmd_stb_i),
    .cmd_o(command_word_i), .sp_o(speed_setpoint_word_i));
  always #50 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Pins are synchronised, so allow four cycles before looking
  task automatic pins(input logic [6:0] p, input logic [15:0] cur,
    input logic [15:0] tmr, input logic [15:0] f, input logic [15:0] exp);
    @(negedge clk_i);
    {off_key_i, local_site_i, start_local_i, coast_local_i, dc_low_i,
      dc_high_i, overtemp_i} = p;
    motor_current_i = cur;
    motor_timer_i = tmr;
    out_freq_i = f;
    repeat (4) @(negedge clk_i);
    chk(drive_state_word_o, exp);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    {off_key_i, start_local_i, coast_local_i, dc_low_i, dc_high_i} = '0;
    {local_site_i, overtemp_i, trip_i, freq_upd_i} = '0;
    {motor_current_i, motor_timer_i, drive_timer_i, out_freq_i} = '0;
    current_limit_i = 16'h01F4;
    freq_low_lim_i = 16'h0064;
    freq_high_lim_i = 16'h03E8;
    freq_max_i = 16'h1000;
    repeat (4) @(negedge clk_i);
    chk(drive_state_word_o, 16'h0000);
    chk(reported_frequency_word_o, 16'h0000);
    nrst_i = 1'b1;
    pins(7'b0110101, 16'h0258, 16'h4001, 16'h01F4, 16'hFC00);
    pins(7'b1000000, 16'h0000, 16'h0000, 16'h01F4, 16'h0400);
    pins(7'b0010010, 16'h01F4, 16'h4000, 16'h03E8, 16'h2200);
    u_mst.send(16'h0448, 16'h2000);
    chk({15'h0000, cmd_taken_o}, 16'h0001);
    chk(target_freq_o, 16'h0800);
    pins(7'b0000000, 16'h0000, 16'h0000, 16'hFE0C, 16'h0E00);
    chk({15'h0000, run_o}, 16'h0001);
    // A trip outranks the halt and holds while overtemperature stays set
    trip_i = 1'b1;
    pins(7'b0000001, 16'h0000, 16'h0000, 16'hFE0C, 16'h0E00);
    trip_i = 1'b0;
    drive_timer_i = 16'h4001;
    pins(7'b0000001, 16'h0000, 16'h0000, 16'hFE0C, 16'h8E00);
    u_mst.send(16'h0048, 16'h1111);
    chk(command_word_o, 16'h0448);
    local_site_i = 1'b1;
    u_mst.send(16'h0400, 16'hC000);
    chk(speed_setpoint_o, 16'h2000);
    local_site_i = 1'b0;
    repeat (3) @(negedge clk_i);
    u_mst.send(16'h0400, 16'hC000);
    chk(target_freq_o, 16'hF000);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      out_freq_i = fv[i];
      freq_upd_i = 1'b1;
      @(negedge clk_i);
      freq_upd_i = 1'b0;
      // A second update while busy must be dropped
      @(negedge clk_i);
      freq_upd_i = 1'b1;
      out_freq_i = 16'h0123;
      @(negedge clk_i);
      freq_upd_i = 1'b0;
      repeat (31) @(negedge clk_i);
      chk(reported_frequency_word_o, fe[i]);
    end
    // A zero full-scale frequency reports zero at once
    freq_max_i = 16'h0000;
    freq_upd_i = 1'b1;
    @(negedge clk_i);
    freq_upd_i = 1'b0;
    chk(reported_frequency_word_o, 16'h0000);
    close_out();
  end
endmodule
